// ===== core/dars_pkg.sv
// Summary of operation
// - Zero saturation selector passes result unchanged.
// - Non-zero selector names the overflow detection bit.
// - Wide output mode keeps saturation selector zero.
// - Chained match also needs upstream match high.
// - Chained match forces rounding method to none.
// - Adder output compared against configurable pattern.
// - Only mask-one bits take part in match.
// - Rounding adds the configurable rounding offset.
// - Load feeds the preload constant as B.
// - Eight-entry constant table, output one cycle later.
// - Reset style option selects asynchronous or synchronous for the adder and output registers only.
// - Clock-enable qualified reset needs adder stage enable.
// - Each optional pipeline register bypassed when off.
// - Shift input moves B right seventeen bits.
// - Feedback B source needs output register, no rounding.
// - Registered output selection needs output register enabled.
// - Pre-adder gives 27-bit result without widening.
// - Chosen rounding method sets pattern, mask, offset.
// - Bypass passes A operand around adder, rounding and saturation, not the output register.
// - Rounding follows add or subtract, precedes saturation.
// - Rounding only while apply-rounding input is high.
package dars_pkg;
   localparam int DW = 64;
   localparam int RF_DEPTH = 8;
   localparam int RF_AW = 3;
   localparam int RF_W = 27;
   localparam int PRE_W = 27;
   localparam int B_SHIFT = 17;
   localparam int SAT_W = 6;
   localparam int RM_W = 3;
   localparam logic [SAT_W-1:0] SAT_NONE = 6'h00;
   localparam logic [RM_W-1:0] RM_NONE = 3'h0;
   localparam logic [RM_W-1:0] RM_NEAREST = 3'h1;
   localparam logic [RM_W-1:0] RM_ZERO = 3'h2;
   localparam logic [RM_W-1:0] RM_INF = 3'h3;
   localparam logic [DW-1:0] PATTERN_RST = 64'h0000_0000_0000_0000;
   localparam logic [DW-1:0] MASK_RST = 64'h0000_0000_0000_0000;
   localparam logic [DW-1:0] ROUND_CONST_RST = 64'h0000_0000_0000_0000;
   localparam logic [DW-1:0] LOAD_CONST_RST = 64'h0000_0000_0000_0000;
   localparam logic [RF_W-1:0] RF_RST = 27'h000_0000;
   localparam logic SEL_B_FEEDBACK = 1'b0;
   localparam logic [1:0] PRE_A_PLUS_B = 2'h0;
   localparam logic [1:0] PRE_A_MINUS_B = 2'h1;
   localparam logic [1:0] PRE_B_MINUS_A = 2'h2;
   localparam int WIDE_POS_BIT = 47;
   localparam int WIDE_NEG_BIT = 46;
   localparam int WIDE_MATCH_BIT = 45;
endpackage : dars_pkg

// ===== core/dars_fab_if.sv
`timescale 1ns/1ps
`default_nettype none
// Fabric side of the add/sub/round/saturate stage.
interface dars_fab_if;
   // Per-cycle controls and operands.
   logic load;
   logic mshift;
   logic rnd;
   logic sub;
   logic ce_addsub;
   logic ce_dout;
   logic rst_addsub;
   logic rst_dout;
   logic [dars_pkg::DW-1:0] b;
   logic [dars_pkg::RF_AW-1:0] reg_addr;
   logic [dars_pkg::PRE_W-1:0] pre_a;
   logic [dars_pkg::PRE_W-1:0] pre_b;
   // Static configuration.
   logic [dars_pkg::SAT_W-1:0] sat_mode;
   logic use_match_in;
   logic [dars_pkg::DW-1:0] match_pattern;
   logic [dars_pkg::DW-1:0] match_mask;
   logic [dars_pkg::DW-1:0] round_const;
   logic [dars_pkg::DW-1:0] load_const;
   logic [dars_pkg::RM_W-1:0] round_mode;
   logic wide48;
   logic sel_b;
   logic addsub_del;
   logic dout_del;
   logic bypass;
   logic [1:0] preadd_mode;
   // Results.
   logic [dars_pkg::DW-1:0] dout;
   logic match;
   logic over_pos;
   logic over_neg;
   logic [dars_pkg::RF_W-1:0] rf_dout;
   logic [dars_pkg::PRE_W-1:0] preadd_dout;

   modport dev (
      input load, mshift, rnd, sub, ce_addsub, ce_dout, rst_addsub, rst_dout, b, reg_addr, pre_a, pre_b,
      input sat_mode, use_match_in, match_pattern, match_mask, round_const, load_const, round_mode,
      input wide48, sel_b, addsub_del, dout_del, bypass, preadd_mode,
      output dout, match, over_pos, over_neg, rf_dout, preadd_dout
   );
   modport fab (
      output load, mshift, rnd, sub, ce_addsub, ce_dout, rst_addsub, rst_dout, b, reg_addr, pre_a, pre_b,
      output sat_mode, use_match_in, match_pattern, match_mask, round_const, load_const, round_mode,
      output wide48, sel_b, addsub_del, dout_del, bypass, preadd_mode,
      input dout, match, over_pos, over_neg, rf_dout, preadd_dout
   );
endinterface : dars_fab_if
`default_nettype wire

// ===== core/dars_dsp_stage.sv
`timescale 1ns/1ps
`default_nettype none
module dars_dsp_stage #(
   parameter bit ASYNC_RST = 1'b0,
   parameter bit RST_CE = 1'b0,
   parameter int SHIFT = dars_pkg::B_SHIFT,
   parameter logic [dars_pkg::RF_DEPTH*dars_pkg::RF_W-1:0] RF_INIT = '0
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Multiplier operand and cascade.
   input wire logic [dars_pkg::DW-1:0] mult_a_i,
   input wire logic casc_match_i,
   output logic casc_match_o,
   // Fabric side.
   dars_fab_if.dev fab
);
   localparam logic [dars_pkg::DW-1:0] ONES = '1;

   logic [dars_pkg::DW-1:0] b_sel;
   logic [dars_pkg::DW-1:0] b_sh;
   logic [dars_pkg::DW-1:0] sum_d;
   logic [dars_pkg::DW-1:0] sum_q;
   logic [dars_pkg::DW-1:0] sum_st;
   logic round_take;
   logic [dars_pkg::DW-1:0] rounded;
   logic [dars_pkg::DW-1:0] hi_mask;
   logic [dars_pkg::DW-1:0] hi_bits;
   logic ovf;
   logic sign;
   logic [dars_pkg::DW-1:0] res_d;
   logic [2:0] flag_d;
   logic [dars_pkg::DW-1:0] dout_q;
   logic [2:0] flag_q;
   logic [dars_pkg::DW-1:0] res_out;
   logic [2:0] flag_out;
   logic match_loc;
   logic rst_sum;
   logic rst_out;
   logic [dars_pkg::RF_W-1:0] rf_mem [dars_pkg::RF_DEPTH];
   logic [dars_pkg::RF_W-1:0] rf_q;
   logic [dars_pkg::PRE_W-1:0] pre_d;
   logic [dars_pkg::PRE_W-1:0] pre_q;

   // Refuse shift amounts the B path cannot serve.
   if (SHIFT < 1 || SHIFT >= dars_pkg::DW) begin : g_bad_shift
      $error("SHIFT must lie between 1 and the data width minus one.");
   end

   // Refuse a table whose index cannot reach every entry.
   if (dars_pkg::RF_DEPTH != (1 << dars_pkg::RF_AW)) begin : g_bad_depth
      $error("RF_DEPTH must equal two to the power RF_AW.");
   end

   // Refuse a saturation selector that cannot name every bit.
   if ((1 << dars_pkg::SAT_W) != dars_pkg::DW) begin : g_bad_sat
      $error("SAT_W must address every bit of the data word.");
   end

   // Refuse wide-output flag bits outside the word or out of order.
   if (dars_pkg::WIDE_POS_BIT >= dars_pkg::DW || dars_pkg::WIDE_NEG_BIT >= dars_pkg::WIDE_POS_BIT ||
       dars_pkg::WIDE_MATCH_BIT >= dars_pkg::WIDE_NEG_BIT) begin : g_bad_wide
      $error("Wide-output flag bits must lie inside the word, in order.");
   end

   // Refuse table and pre-adder words wider than the data word.
   if (dars_pkg::RF_W > dars_pkg::DW || dars_pkg::PRE_W > dars_pkg::DW) begin : g_bad_width
      $error("Table and pre-adder words must fit the data word.");
   end

   // Constant table contents, one entry per index.
   for (genvar i = 0; i < dars_pkg::RF_DEPTH; i++) begin : g_rf
      assign rf_mem[i] = RF_INIT[i*dars_pkg::RF_W +: dars_pkg::RF_W];
   end

   // B operand selection, preload and shift, then add or subtract.
   always_comb begin
      b_sel = (fab.sel_b == dars_pkg::SEL_B_FEEDBACK) ? dout_q : fab.b;
      if (fab.load) begin
         b_sel = fab.load_const;
      end
      b_sh = fab.mshift ? dars_pkg::DW'($signed(b_sel) >>> SHIFT) : b_sel;
      sum_d = fab.sub ? mult_a_i - b_sh : mult_a_i + b_sh;
   end

   // Stage resets; the adder stage may wait for its clock enable.
   assign rst_sum = rst_i | (fab.rst_addsub & (~RST_CE | fab.ce_addsub));
   assign rst_out = rst_i | fab.rst_dout;

   // Optional adder-stage register.
   assign sum_st = fab.addsub_del ? sum_q : sum_d;

   // Pattern match on the adder output, optionally chained.
   assign match_loc = ((sum_st ^ fab.match_pattern) & fab.match_mask) == '0;
   assign casc_match_o = match_loc & (~fab.use_match_in | casc_match_i);

   // Rounding after the adder and before saturation, gated by the round input.
   always_comb begin
      sign = sum_st[dars_pkg::DW-1];
      case (fab.round_mode)
         dars_pkg::RM_NONE: round_take = 1'b0;
         dars_pkg::RM_ZERO: round_take = sign;
         dars_pkg::RM_INF: round_take = ~sign;
         default: round_take = 1'b1;
      endcase
      round_take = round_take & fab.rnd;
      rounded = round_take ? sum_st + fab.round_const : sum_st;
   end

   // Saturation at the selected bit, then the bypass path.
   always_comb begin
      hi_mask = ONES << fab.sat_mode;
      hi_bits = rounded & hi_mask;
      ovf = (fab.sat_mode != dars_pkg::SAT_NONE) && (hi_bits != '0) && (hi_bits != hi_mask);
      if (!ovf) begin
         res_d = rounded;
      end else if (rounded[dars_pkg::DW-1]) begin
         res_d = hi_mask;
      end else begin
         res_d = ~hi_mask;
      end
      flag_d = {ovf & ~rounded[dars_pkg::DW-1], ovf & rounded[dars_pkg::DW-1], casc_match_o};
      if (fab.bypass) begin
         res_d = mult_a_i;
         flag_d = 3'h0;
      end
   end

   // Registers under the chosen reset style.
   if (ASYNC_RST) begin : g_async
      always_ff @(posedge ref_clk_i or posedge rst_sum) begin
         if (rst_sum) begin
            sum_q <= '0;
         end else if (fab.ce_addsub) begin
            sum_q <= sum_d;
         end
      end
      always_ff @(posedge ref_clk_i or posedge rst_out) begin
         if (rst_out) begin
            dout_q <= '0;
            flag_q <= 3'h0;
         end else if (fab.ce_dout) begin
            dout_q <= res_d;
            flag_q <= flag_d;
         end
      end
   end else begin : g_sync
      always_ff @(posedge ref_clk_i) begin
         if (rst_sum) begin
            sum_q <= '0;
         end else if (fab.ce_addsub) begin
            sum_q <= sum_d;
         end
      end
      always_ff @(posedge ref_clk_i) begin
         if (rst_out) begin
            dout_q <= '0;
            flag_q <= 3'h0;
         end else if (fab.ce_dout) begin
            dout_q <= res_d;
            flag_q <= flag_d;
         end
      end
   end

   // Optional output register and the wide-output flag reuse.
   always_comb begin
      res_out = fab.dout_del ? dout_q : res_d;
      flag_out = fab.dout_del ? flag_q : flag_d;
      if (fab.wide48) begin
         flag_out = {res_out[dars_pkg::WIDE_POS_BIT], res_out[dars_pkg::WIDE_NEG_BIT],
                     res_out[dars_pkg::WIDE_MATCH_BIT]};
      end
   end
   assign fab.dout = res_out;
   assign fab.over_pos = flag_out[2];
   assign fab.over_neg = flag_out[1];
   assign fab.match = flag_out[0];

   // Constant table read, one cycle after the index.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rf_q <= dars_pkg::RF_RST;
      end else begin
         rf_q <= rf_mem[fab.reg_addr];
      end
   end
   assign fab.rf_dout = rf_q;

   // Pre-adder without widening; the carry out of bit 26 is dropped.
   always_comb begin
      case (fab.preadd_mode)
         dars_pkg::PRE_A_MINUS_B: pre_d = fab.pre_a - fab.pre_b;
         dars_pkg::PRE_B_MINUS_A: pre_d = fab.pre_b - fab.pre_a;
         default: pre_d = fab.pre_a + fab.pre_b;
      endcase
   end
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_d;
      end
   end
   assign fab.preadd_dout = pre_q;
endmodule : dars_dsp_stage
`default_nettype wire

// ===== core/dars_fab_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module dars_fab_ctl (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // User controls and operands.
   input wire logic usr_load_i,
   input wire logic usr_mshift_i,
   input wire logic usr_rnd_i,
   input wire logic usr_sub_i,
   input wire logic usr_ce_addsub_i,
   input wire logic usr_ce_dout_i,
   input wire logic usr_rst_addsub_i,
   input wire logic usr_rst_dout_i,
   input wire logic [dars_pkg::DW-1:0] usr_b_i,
   input wire logic [dars_pkg::RF_AW-1:0] usr_reg_addr_i,
   input wire logic [dars_pkg::PRE_W-1:0] usr_pre_a_i,
   input wire logic [dars_pkg::PRE_W-1:0] usr_pre_b_i,
   // User configuration.
   input wire logic [dars_pkg::SAT_W-1:0] usr_sat_mode_i,
   input wire logic usr_use_match_in_i,
   input wire logic [dars_pkg::RM_W-1:0] usr_round_mode_i,
   input wire logic [5:0] usr_round_frac_i,
   input wire logic [dars_pkg::DW-1:0] usr_load_const_i,
   input wire logic usr_wide48_i,
   input wire logic usr_sel_b_i,
   input wire logic usr_addsub_del_i,
   input wire logic usr_dout_del_i,
   input wire logic usr_bypass_i,
   input wire logic [1:0] usr_preadd_mode_i,
   // Results to the user.
   output logic [dars_pkg::DW-1:0] usr_dout_o,
   output logic usr_match_o,
   output logic usr_over_pos_o,
   output logic usr_over_neg_o,
   output logic [dars_pkg::RF_W-1:0] usr_rf_dout_o,
   output logic [dars_pkg::PRE_W-1:0] usr_preadd_dout_o,
   // Stage side.
   dars_fab_if.fab fab
);
   logic rm_forced_none;
   logic [dars_pkg::RM_W-1:0] rm_legal;
   logic [dars_pkg::DW-1:0] frac_mask;
   logic [dars_pkg::DW-1:0] frac_half;
   logic half_mode;

   // Legal rounding method and the fraction patterns that go with it.
   always_comb begin
      rm_forced_none = usr_use_match_in_i | (usr_sel_b_i == dars_pkg::SEL_B_FEEDBACK);
      rm_legal = rm_forced_none ? dars_pkg::RM_NONE : usr_round_mode_i;
      frac_mask = (64'h0000_0000_0000_0001 << usr_round_frac_i) - 64'h0000_0000_0000_0001;
      frac_half = (usr_round_frac_i == 6'h00) ? '0 : (64'h0000_0000_0000_0001 << (usr_round_frac_i - 6'h01));
      half_mode = (rm_legal == dars_pkg::RM_NEAREST) || (rm_legal > 3'h4);
   end

   // Per-cycle controls, registered toward the stage.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         {fab.load, fab.mshift, fab.rnd, fab.sub} <= 4'h0;
         {fab.ce_addsub, fab.ce_dout, fab.rst_addsub, fab.rst_dout} <= 4'h3;
         fab.b <= '0;
         fab.reg_addr <= '0;
         fab.pre_a <= '0;
         fab.pre_b <= '0;
      end else begin
         {fab.load, fab.mshift, fab.rnd, fab.sub} <= {usr_load_i, usr_mshift_i, usr_rnd_i, usr_sub_i};
         {fab.ce_addsub, fab.ce_dout} <= {usr_ce_addsub_i, usr_ce_dout_i};
         {fab.rst_addsub, fab.rst_dout} <= {usr_rst_addsub_i, usr_rst_dout_i};
         fab.b <= usr_b_i;
         fab.reg_addr <= usr_reg_addr_i;
         fab.pre_a <= usr_pre_a_i;
         fab.pre_b <= usr_pre_b_i;
      end
   end

   // Configuration, held legal out of reset; reset loads feedback B with the output register off.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         fab.sat_mode <= dars_pkg::SAT_NONE;
         fab.use_match_in <= 1'b0;
         fab.round_mode <= dars_pkg::RM_NONE;
         fab.match_pattern <= dars_pkg::PATTERN_RST;
         fab.match_mask <= dars_pkg::MASK_RST;
         fab.round_const <= dars_pkg::ROUND_CONST_RST;
         fab.load_const <= dars_pkg::LOAD_CONST_RST;
         {fab.wide48, fab.sel_b, fab.addsub_del, fab.dout_del, fab.bypass} <= 5'h0;
         fab.preadd_mode <= dars_pkg::PRE_A_PLUS_B;
      end else begin
         fab.sat_mode <= usr_wide48_i ? dars_pkg::SAT_NONE : usr_sat_mode_i;
         fab.use_match_in <= usr_use_match_in_i;
         fab.round_mode <= rm_legal;
         if (rm_legal != dars_pkg::RM_NONE) begin
            fab.match_pattern <= half_mode ? frac_half : '0;
            fab.match_mask <= frac_mask;
            fab.round_const <= half_mode ? frac_half : frac_mask;
         end else begin
            fab.match_pattern <= dars_pkg::PATTERN_RST;
            fab.match_mask <= dars_pkg::MASK_RST;
            fab.round_const <= dars_pkg::ROUND_CONST_RST;
         end
         fab.load_const <= usr_load_const_i;
         fab.wide48 <= usr_wide48_i;
         fab.sel_b <= usr_sel_b_i;
         fab.addsub_del <= usr_addsub_del_i;
         fab.dout_del <= usr_dout_del_i | (usr_sel_b_i == dars_pkg::SEL_B_FEEDBACK);
         fab.bypass <= usr_bypass_i;
         fab.preadd_mode <= usr_preadd_mode_i;
      end
   end

   // Results, registered toward the user.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         usr_dout_o <= '0;
         {usr_match_o, usr_over_pos_o, usr_over_neg_o} <= 3'h0;
         usr_rf_dout_o <= '0;
         usr_preadd_dout_o <= '0;
      end else begin
         usr_dout_o <= fab.dout;
         {usr_match_o, usr_over_pos_o, usr_over_neg_o} <= {fab.match, fab.over_pos, fab.over_neg};
         usr_rf_dout_o <= fab.rf_dout;
         usr_preadd_dout_o <= fab.preadd_dout;
      end
   end
endmodule : dars_fab_ctl
`default_nettype wire

// ===== testbench/dars_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dars_properties #(
   parameter logic [dars_pkg::RF_DEPTH*dars_pkg::RF_W-1:0] RF_INIT = '0
) (
   // Clock, reset and stage pins.
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [63:0] mult_a_i,
   input wire logic casc_match_i,
   input wire logic casc_match_o,
   // Controls and operands.
   input wire logic load,
   input wire logic mshift,
   input wire logic rnd,
   input wire logic sub,
   input wire logic ce_dout,
   input wire logic rst_dout,
   input wire logic [63:0] b,
   input wire logic [2:0] reg_addr,
   input wire logic [26:0] pre_a,
   input wire logic [26:0] pre_b,
   // Configuration.
   input wire logic [5:0] sat_mode,
   input wire logic use_match_in,
   input wire logic [63:0] match_pattern,
   input wire logic [63:0] match_mask,
   input wire logic [63:0] round_const,
   input wire logic [63:0] load_const,
   input wire logic [2:0] round_mode,
   input wire logic sel_b,
   input wire logic addsub_del,
   input wire logic dout_del,
   input wire logic bypass,
   input wire logic [1:0] preadd_mode,
   // Results.
   input wire logic [63:0] dout,
   input wire logic over_pos,
   input wire logic over_neg,
   input wire logic [26:0] rf_dout,
   input wire logic [26:0] preadd_dout
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   logic [63:0] bsel, sum, rsum, hi, sat_v;
   logic m_loc, path;

   // Pre-adder reference with 27-bit wrap.
   function automatic logic [26:0] padd(input logic [26:0] x, input logic [26:0] y, input logic [1:0] m);
      return (m == 2'h1) ? x - y : (m == 2'h2) ? y - x : x + y;
   endfunction : padd

   // Reference of the combinational sum, round and saturate path.
   always_comb begin
      bsel = load ? load_const : b;
      if (mshift) bsel = $signed(bsel) >>> 17;
      sum = sub ? mult_a_i - bsel : mult_a_i + bsel;
      rsum = sum;
      if (rnd && round_mode != 3'h0 && !(round_mode == 3'h2 && !sum[63]) && !(round_mode == 3'h3 && sum[63]))
         rsum = sum + round_const;
      hi = $signed(rsum) >>> sat_mode;
      sat_v = rsum;
      if (sat_mode != 6'h0 && hi != 64'h0 && hi != ~64'h0) sat_v = rsum[63] ? ~64'h0 << sat_mode : ~(~64'h0 << sat_mode);
      m_loc = ((sum ^ match_pattern) & match_mask) == 64'h0;
      path = sel_b && !dout_del && !addsub_del && !bypass;
   end

   a_pass_plain: assert property (path && sat_mode == 6'h0 && !rnd |-> dout == sum)
      else $error("plain sum differs");
   a_round_offset: assert property (path && sat_mode == 6'h0 && rnd |-> dout == rsum)
      else $error("rounded sum differs");
   a_sat_clamp: assert property (path && sat_mode != 6'h0 |-> dout == sat_v)
      else $error("saturated sum differs");
   a_match_chain: assert property (path |-> casc_match_o == (m_loc && (!use_match_in || casc_match_i)))
      else $error("cascade match differs");
   a_bypass_a: assert property (bypass && !dout_del && !addsub_del |-> dout == mult_a_i && !over_pos && !over_neg)
      else $error("bypass result differs");
   a_dout_hold: assert property (dout_del && !ce_dout && !rst_dout ##1 dout_del |-> $stable(dout))
      else $error("held output changed");
   a_stage_reset: assert property (rst_dout && dout_del ##1 dout_del |-> dout == 64'h0)
      else $error("output stage not cleared");
   a_table_entry: assert property (!$past(rst_i) |-> rf_dout == RF_INIT[27*$past(reg_addr) +: 27])
      else $error("table entry differs");
   a_preadd_mode: assert property (!$past(rst_i) |-> preadd_dout == padd($past(pre_a), $past(pre_b), $past(preadd_mode)))
      else $error("pre-adder result differs");
endmodule : dars_properties
`default_nettype wire

// ===== testbench/test_dsp_addsub_round_saturate.sv
`timescale 1ns/1ps
`default_nettype none
module test_dsp_addsub_round_saturate;
   localparam logic [215:0] RF_INIT = {27'h700_0007, 27'h600_0006, 27'h500_0005, 27'h400_0004,
      27'h300_0003, 27'h200_0002, 27'h100_0001, 27'h000_0000};
   logic ref_clk_i = 1'b0, rst_i = 1'b1, ld = 1'b0, msh = 1'b0, rnd = 1'b0, sub = 1'b0, ce_do = 1'b1;
   logic rst_do = 1'b0, umi = 1'b0, selb = 1'b1, dodel = 1'b0, byp = 1'b0, casc_in = 1'b0;
   logic match, ovp, ovn, casc_out;
   logic w48 = 1'b0, asdel = 1'b0, ce_as = 1'b1, rst_as = 1'b0;
   logic [63:0] bv = 64'h0, lconst = 64'h0, mult_a = 64'h0, dout;
   logic [2:0] raddr = 3'h0, rmode = 3'h0;
   logic [5:0] sat = 6'h0, frac = 6'h0;
   logic [26:0] pa = 27'h0, pb = 27'h0, rfd, pred;
   logic [1:0] pmode = 2'h0;
   logic [63:0] rexp [8] = '{64'h13, 64'h1B, 64'h13, 64'h22, 64'h22, 64'h1B, 64'h1B, 64'h1B};
   logic [26:0] pexp [4] = '{27'hD, 27'h7, 27'h7FF_FFF9, 27'hD};
   int n_fail = 0, tests_run = 0, cyc = 0;

   // The two ends meet across one interface.
   dars_fab_if fi ();
   dars_dsp_stage #(.RF_INIT(RF_INIT), .RST_CE(1'b1)) dars_dsp_stage_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .mult_a_i(mult_a), .casc_match_i(casc_in), .casc_match_o(casc_out), .fab(fi.dev));
   dars_fab_ctl dars_fab_ctl_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .usr_load_i(ld), .usr_mshift_i(msh),
      .usr_rnd_i(rnd), .usr_sub_i(sub), .usr_ce_addsub_i(ce_as), .usr_ce_dout_i(ce_do), .usr_rst_addsub_i(rst_as),
      .usr_rst_dout_i(rst_do), .usr_b_i(bv), .usr_reg_addr_i(raddr), .usr_pre_a_i(pa), .usr_pre_b_i(pb),
      .usr_sat_mode_i(sat), .usr_use_match_in_i(umi), .usr_round_mode_i(rmode), .usr_round_frac_i(frac),
      .usr_load_const_i(lconst), .usr_wide48_i(w48), .usr_sel_b_i(selb), .usr_addsub_del_i(asdel),
      .usr_dout_del_i(dodel), .usr_bypass_i(byp), .usr_preadd_mode_i(pmode), .usr_dout_o(dout),
      .usr_match_o(match), .usr_over_pos_o(ovp), .usr_over_neg_o(ovn), .usr_rf_dout_o(rfd),
      .usr_preadd_dout_o(pred), .fab(fi.fab));
   dars_properties #(.RF_INIT(RF_INIT)) dars_properties_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .mult_a_i(mult_a), .casc_match_i(casc_in), .casc_match_o(casc_out), .load(fi.load), .mshift(fi.mshift),
      .rnd(fi.rnd), .sub(fi.sub), .ce_dout(fi.ce_dout), .rst_dout(fi.rst_dout), .b(fi.b), .reg_addr(fi.reg_addr),
      .pre_a(fi.pre_a), .pre_b(fi.pre_b), .sat_mode(fi.sat_mode), .use_match_in(fi.use_match_in),
      .match_pattern(fi.match_pattern), .match_mask(fi.match_mask), .round_const(fi.round_const),
      .load_const(fi.load_const), .round_mode(fi.round_mode), .sel_b(fi.sel_b), .addsub_del(fi.addsub_del),
      .dout_del(fi.dout_del), .bypass(fi.bypass), .preadd_mode(fi.preadd_mode), .dout(fi.dout),
      .over_pos(fi.over_pos), .over_neg(fi.over_neg), .rf_dout(fi.rf_dout), .preadd_dout(fi.preadd_dout));

   // Free-running clock.
   initial begin
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   // Prints the verdict and ends the run.
   task automatic conclude();
      if (n_fail == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   // Cuts a hang short.
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_fail++;
         conclude();
      end
   end

   // Lets n edges pass, then settles to the falling edge.
   task automatic go(input int n);
      repeat (n) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask : go

   // Applies both adder operands and waits for the result to settle.
   task automatic apply(input logic [63:0] a, input logic [63:0] bb);
      @(posedge ref_clk_i);
      mult_a <= a;
      bv <= bb;
      go(4);
   endtask : apply

   task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : chk64

   task automatic chk1(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask : chk1

   // Main sequence: each step sets controls at an edge, then checks settled results.
   initial begin
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      apply(64'h2, 64'h5); chk64(dout, 64'h7);
      @(posedge ref_clk_i); sub <= 1'b1;
      apply(64'h2, 64'h5); chk64(dout, 64'hFFFF_FFFF_FFFF_FFFD);
      @(posedge ref_clk_i); sub <= 1'b0; ld <= 1'b1; lconst <= 64'h100;
      apply(64'h2, 64'h5); chk64(dout, 64'h102);
      @(posedge ref_clk_i); ld <= 1'b0; msh <= 1'b1;
      apply(64'h2, 64'h1_0000_0000); chk64(dout, 64'h8002);
      @(posedge ref_clk_i); msh <= 1'b0; rnd <= 1'b1; frac <= 6'h4;
      for (int m = 0; m < 8; m++) begin
         @(posedge ref_clk_i); rmode <= m[2:0];
         apply(64'h13, 64'h0); chk64(dout, rexp[m]);
      end
      @(posedge ref_clk_i); rnd <= 1'b0; rmode <= 3'h1;
      apply(64'h18, 64'h0); chk64(dout, 64'h18); chk1(match, 1'b1);
      apply(64'h38, 64'h0); chk1(match, 1'b1);
      apply(64'h19, 64'h0); chk1(match, 1'b0);
      for (int k = 0; k < 3; k++) begin
         @(posedge ref_clk_i); umi <= (k < 2); casc_in <= (k == 1);
         apply(64'h8, 64'h0); chk1(match, k > 0);
      end
      @(posedge ref_clk_i); umi <= 1'b0; casc_in <= 1'b0; rmode <= 3'h0; sat <= 6'h8;
      apply(64'hFF, 64'h0); chk64(dout, 64'hFF); chk1(ovp, 1'b0);
      apply(64'h100, 64'h0); chk64(dout, 64'hFF); chk1(ovp, 1'b1);
      apply(64'hFFFF_FFFF_FFFF_F000, 64'h0); chk64(dout, 64'hFFFF_FFFF_FFFF_FF00); chk1(ovn, 1'b1);
      @(posedge ref_clk_i); sat <= 6'h0;
      apply(64'h1000, 64'h0); chk64(dout, 64'h1000);
      @(posedge ref_clk_i); byp <= 1'b1;
      apply(64'h1234, 64'h5); chk64(dout, 64'h1234);
      @(posedge ref_clk_i); byp <= 1'b0; dodel <= 1'b1;
      apply(64'h40, 64'h1); chk64(dout, 64'h41);
      @(posedge ref_clk_i); ce_do <= 1'b0;
      apply(64'h50, 64'h1); chk64(dout, 64'h41);
      @(posedge ref_clk_i); ce_do <= 1'b1; rst_do <= 1'b1;
      go(4); chk64(dout, 64'h0);
      @(posedge ref_clk_i); rst_do <= 1'b0; dodel <= 1'b0;
      @(posedge ref_clk_i); w48 <= 1'b1; sat <= 6'h8;
      apply(64'h0000_C000_0000_0100, 64'h0); chk64(dout, 64'h0000_C000_0000_0100);
      chk1(ovp, 1'b1); chk1(ovn, 1'b1); chk1(match, 1'b0);
      @(posedge ref_clk_i); w48 <= 1'b0; sat <= 6'h0; umi <= 1'b1; rnd <= 1'b1; rmode <= 3'h1;
      apply(64'h13, 64'h0); chk64(dout, 64'h13);
      @(posedge ref_clk_i); umi <= 1'b0; rnd <= 1'b0; rmode <= 3'h0; asdel <= 1'b1;
      apply(64'h40, 64'h1); chk64(dout, 64'h41);
      @(posedge ref_clk_i); ce_as <= 1'b0; rst_as <= 1'b1;
      apply(64'h50, 64'h1); chk64(dout, 64'h41);
      @(posedge ref_clk_i); ce_as <= 1'b1;
      go(4); chk64(dout, 64'h0);
      @(posedge ref_clk_i); rst_as <= 1'b0; asdel <= 1'b0; selb <= 1'b0; rnd <= 1'b1; rmode <= 3'h1;
      mult_a <= 64'h3; ce_do <= 1'b0; rst_do <= 1'b1;
      go(4); chk64(dout, 64'h0);
      for (int p = 1; p < 3; p++) begin
         @(posedge ref_clk_i); rst_do <= 1'b0; ce_do <= 1'b1;
         @(posedge ref_clk_i); ce_do <= 1'b0;
         go(3); chk64(dout, 64'h3 * p);
      end
      @(posedge ref_clk_i); selb <= 1'b1; rnd <= 1'b0; rmode <= 3'h0; ce_do <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk_i); raddr <= i[2:0];
         go(3); chk64(rfd, i * 27'h100_0001);
      end
      @(posedge ref_clk_i); pa <= 27'hA; pb <= 27'h3;
      for (int m = 0; m < 4; m++) begin
         @(posedge ref_clk_i); pmode <= m[1:0];
         go(4); chk64(pred, pexp[m]);
      end
      conclude();
   end
endmodule : test_dsp_addsub_round_saturate
`default_nettype wire
